/* exchange_pkg.sv */
// package for the fixed slot position exchange block
// assumes one 40 MHz clock and a master that drives slot words on the same clock
package exchange_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned POS_W = 32;
  localparam int unsigned SLOT_WORDS = 4;
  localparam int unsigned AXES = 2;
  localparam int unsigned IDX_DET_LO = 0;
  localparam int unsigned IDX_DET_HI = 1;
  localparam int unsigned IDX_POS_LO = 2;
  localparam int unsigned IDX_POS_HI = 3;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STEP_RATE_HZ = 1_000_000;
  localparam int unsigned STEP_CYCLES = CLK_HZ / STEP_RATE_HZ;

  typedef enum logic [1:0] {
    MOVE_IDLE = 2'b00,
    MOVE_RUN = 2'b01,
    MOVE_DONE = 2'b10
  } move_state_t;

  typedef struct packed {
    logic read_req;
    logic write_req;
    logic start;
  } axis_ctrl_t;

  typedef struct packed {
    logic read_active_flag;
    logic write_active_flag;
    logic busy;
  } axis_resp_t;
endpackage

/* axis_mover.sv */
// single axis position generator: steps detected position toward a target
// assumes start is already synchronised to sys_clk_i
`timescale 1ns/1ps
module axis_mover #(
  parameter int unsigned POS_W = exchange_pkg::POS_W,
  parameter int unsigned STEP_CYCLES = exchange_pkg::STEP_CYCLES
)(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [POS_W-1:0] target_i,
  output logic [POS_W-1:0] position_o,
  output logic busy_o
);
  if (STEP_CYCLES < 1 || POS_W < 2)
  begin : g_bad_params
    $error("axis_mover: bad parameters");
  end

  exchange_pkg::move_state_t state;
  logic [POS_W-1:0] target;
  logic [31:0] tick;
  logic start_q;

  // **********
  // move sequence
  // **********
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= exchange_pkg::MOVE_IDLE;
      target <= '0;
      start_q <= 1'b0;
      tick <= '0;
      position_o <= '0;
      busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      start_q <= start_i;
      case (state)
        exchange_pkg::MOVE_IDLE, exchange_pkg::MOVE_DONE:
        begin
          busy_o <= 1'b0;
          if (start_i && !start_q)
          begin
            target <= target_i;
            tick <= '0;
            state <= exchange_pkg::MOVE_RUN;
            busy_o <= 1'b1;
          end
        end
        exchange_pkg::MOVE_RUN:
        begin
          // move carries on regardless of start level
          if (position_o == target)
          begin
            state <= exchange_pkg::MOVE_DONE;
            busy_o <= 1'b0;
          end
          else if (tick == 32'(STEP_CYCLES - 1))
          begin
            tick <= '0;
            if ($signed(target - position_o) > 0)
              position_o <= position_o + 1'b1;
            else
              position_o <= position_o - 1'b1;
          end
          else
            tick <= tick + 32'd1;
        end
        default:
          state <= exchange_pkg::MOVE_IDLE;
      endcase
    end
  end
endmodule

/* fixed_slot_position_exchange.sv */
// fixed four-word slot exchange for two axes with read and write handshakes
// assumes master words and request bits are on sys_clk_i; bits are synchronised anyway
// Behaviour
// - each axis read slot carries detected position and stored entry zero
// - read-active flag follows the read request, three cycles after it changes
// - with the synchronised read request set (one cycle before read-active), detected position and entry zero fill the read slot
// - read slot refreshes every cycle while read request is held
// - entry zero reads as zero until first write
// - write-active flag follows the write request, three cycles after it changes
// - a new entry zero shows in the read slot the cycle after it is stored
// - entry zero rewritten every cycle while write request held
// - move continues to target after start is released
// - detected position equals target when move completes
`timescale 1ns/1ps
module fixed_slot_position_exchange #(
  parameter int unsigned AXES = exchange_pkg::AXES,
  parameter int unsigned STEP_CYCLES = exchange_pkg::STEP_CYCLES
)(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire exchange_pkg::axis_ctrl_t [AXES-1:0] ctrl_i,
  input wire logic [AXES-1:0][exchange_pkg::SLOT_WORDS-1:0][exchange_pkg::WORD_W-1:0]
    write_word_slot_i,
  output logic [AXES-1:0][exchange_pkg::SLOT_WORDS-1:0][exchange_pkg::WORD_W-1:0]
    read_word_slot_o,
  output exchange_pkg::axis_resp_t [AXES-1:0] resp_o
);
  if (AXES < 1 || AXES > 16)
  begin : g_bad_axes
    $error("fixed_slot_position_exchange: bad AXES");
  end
  if (STEP_CYCLES < 1)
  begin : g_bad_step
    $error("fixed_slot_position_exchange: bad STEP_CYCLES");
  end

  function automatic logic [exchange_pkg::POS_W-1:0] join_words(
    input logic [exchange_pkg::WORD_W-1:0] lo,
    input logic [exchange_pkg::WORD_W-1:0] hi
  );
    join_words = {hi, lo};
  endfunction

  function automatic logic [exchange_pkg::WORD_W-1:0] lo_half(
    input logic [exchange_pkg::POS_W-1:0] value
  );
    lo_half = value[exchange_pkg::WORD_W-1:0];
  endfunction

  function automatic logic [exchange_pkg::WORD_W-1:0] hi_half(
    input logic [exchange_pkg::POS_W-1:0] value
  );
    hi_half = value[exchange_pkg::POS_W-1:exchange_pkg::WORD_W];
  endfunction

  genvar g;
  generate
    for (g = 0; g < AXES; g++)
    begin : axis
      // **********
      // request synchronisers
      // **********
      exchange_pkg::axis_ctrl_t meta;
      exchange_pkg::axis_ctrl_t sync;
      logic [exchange_pkg::POS_W-1:0] entry_zero;
      logic [exchange_pkg::POS_W-1:0] detected;
      logic moving;

      always_ff @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          meta <= '0;
          sync <= '0;
        end
        else if (ce_i)
        begin
          meta <= ctrl_i[g];
          sync <= meta;
        end
      end

      // **********
      // stored entry zero
      // **********
      always_ff @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          entry_zero <= exchange_pkg::POS_RESET;
        else if (ce_i && sync.write_req)
          // continuous rewrite from lower and upper words
          entry_zero <= join_words(write_word_slot_i[g][exchange_pkg::IDX_POS_LO],
                                   write_word_slot_i[g][exchange_pkg::IDX_POS_HI]);
      end

      axis_mover #(
        .POS_W(exchange_pkg::POS_W),
        .STEP_CYCLES(STEP_CYCLES)
      ) u_mover (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .start_i(sync.start),
        .target_i(entry_zero),
        .position_o(detected),
        .busy_o(moving)
      );

      // **********
      // response flags
      // **********
      always_ff @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          resp_o[g] <= '0;
        else if (ce_i)
        begin
          resp_o[g].read_active_flag <= sync.read_req;
          resp_o[g].write_active_flag <= sync.write_req;
          resp_o[g].busy <= moving;
        end
      end

      // **********
      // read slot
      // **********
      always_ff @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          read_word_slot_o[g] <= '0;
        else if (ce_i && sync.read_req)
        begin
          // refresh every cycle while requested
          read_word_slot_o[g][exchange_pkg::IDX_DET_LO] <= lo_half(detected);
          read_word_slot_o[g][exchange_pkg::IDX_DET_HI] <= hi_half(detected);
          // new value visible the cycle after it is stored
          read_word_slot_o[g][exchange_pkg::IDX_POS_LO] <= lo_half(entry_zero);
          read_word_slot_o[g][exchange_pkg::IDX_POS_HI] <= hi_half(entry_zero);
        end
      end
    end
  endgenerate
endmodule

/* fsp_assertions.sv */
// checker for the slot exchange handshakes of axis 0
// assumes ce_i stays high around request and start changes
`timescale 1ns/1ps
module fsp_checker #(
  parameter int unsigned AXES = 2,
  parameter int unsigned STEP_CYCLES = 1
)(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire exchange_pkg::axis_ctrl_t [AXES-1:0] ctrl_i,
  input wire logic [AXES-1:0][3:0][15:0] write_word_slot_i,
  input wire logic [AXES-1:0][3:0][15:0] read_word_slot_o,
  input wire exchange_pkg::axis_resp_t [AXES-1:0] resp_o
);
  logic wrote;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wrote <= 1'b0;
    else if (resp_o[0].write_active_flag)
      wrote <= 1'b1;
  end
  sequence s_held(sig, v);
    $changed(sig) && sig == v ##1 (sig == v) [*2];
  endsequence
  sequence s_steady;
    (resp_o[0].read_active_flag && resp_o[0].write_active_flag &&
      $stable(write_word_slot_i[0][3:2])) [*3];
  endsequence
  a_read_flag_rise: assert property (s_held(ctrl_i[0].read_req, 1'b1) |=>
    resp_o[0].read_active_flag) else $error("read flag not raised");
  a_read_flag_clear: assert property (s_held(ctrl_i[0].read_req, 1'b0) |=>
    !resp_o[0].read_active_flag) else $error("read flag not cleared");
  a_write_flag_rise: assert property (s_held(ctrl_i[0].write_req, 1'b1) |=>
    resp_o[0].write_active_flag) else $error("write flag not raised");
  a_write_flag_clear: assert property (s_held(ctrl_i[0].write_req, 1'b0) |=>
    !resp_o[0].write_active_flag) else $error("write flag not cleared");
  a_slot_held_idle: assert property (!resp_o[0].read_active_flag |->
    $stable(read_word_slot_o[0])) else $error("slot moved while idle");
  a_entry_zero_init: assert property (!wrote && !resp_o[0].write_active_flag |->
    read_word_slot_o[0][3:2] == 32'h0) else $error("entry not zero");
  a_entry_shown: assert property (s_steady |->
    read_word_slot_o[0][3:2] == write_word_slot_i[0][3:2]) else $error("entry not shown");
  a_move_starts: assert property ($rose(ctrl_i[0].start) && !resp_o[0].busy |->
    ##[1:8] resp_o[0].busy) else $error("move not started");
endmodule
bind fixed_slot_position_exchange fsp_checker #(.AXES(AXES), .STEP_CYCLES(STEP_CYCLES))
  chk_u (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .ctrl_i(ctrl_i),
    .write_word_slot_i(write_word_slot_i),
    .read_word_slot_o(read_word_slot_o),
    .resp_o(resp_o)
  );

/* slot_master.sv */
// master model: turns bench levels into request bits and write words
// assumes one clock; drives on the falling edge
`timescale 1ns/1ps
module slot_master #(
  parameter int unsigned AXES = 2
)(
  input wire logic sys_clk_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic st_i,
  input wire logic [31:0] pos_i,
  output exchange_pkg::axis_ctrl_t [AXES-1:0] ctrl_o,
  output logic [AXES-1:0][3:0][15:0] words_o
);
  initial ctrl_o = '0;
  initial words_o = '0;
  always @(negedge sys_clk_i)
  begin
    for (int a = 0; a < AXES; a++)
    begin
      ctrl_o[a] <= {rd_i, wr_i, st_i};
      words_o[a] <= {pos_i, 32'($urandom)};
    end
  end
endmodule

/* fixed_slot_position_exchange_test.sv */
// bench: master model drives, queue of notes checked on flag rise and move end
// assumes STEP_CYCLES of 1
`timescale 1ns/1ps
module fixed_slot_position_exchange_test;
  logic sys_clk_i = 0;
  logic rstn_i = 0;
  logic rd = 0, wr = 0, st = 0;
  logic ce = 1;
  logic [31:0] pos = '0;
  exchange_pkg::axis_ctrl_t [1:0] ctrl;
  logic [1:0][3:0][15:0] wslot, rslot;
  logic [1:0][3:0][15:0] snap;
  exchange_pkg::axis_resp_t [1:0] resp;
  logic [63:0] notes[$];
  logic [63:0] exp;
  int n_errors = 0;
  int samples_checked = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  slot_master #(.AXES(2)) m_u (.sys_clk_i(sys_clk_i), .rd_i(rd), .wr_i(wr), .st_i(st),
    .pos_i(pos), .ctrl_o(ctrl), .words_o(wslot));
  fixed_slot_position_exchange #(.AXES(2), .STEP_CYCLES(1)) dut_u (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .ce_i(ce), .ctrl_i(ctrl), .write_word_slot_i(wslot),
    .read_word_slot_o(rslot), .resp_o(resp));
  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge resp[0].read_active_flag or negedge resp[0].busy)
  begin
    repeat (2) @(negedge sys_clk_i);
    if (notes.size() > 0)
    begin
      exp = notes.pop_front();
      for (int a = 0; a < 2; a++)
      begin
        samples_checked++;
        if ({rslot[a][1], rslot[a][0], rslot[a][3], rslot[a][2]} !== exp)
        begin
          n_errors++;
          $display("MISMATCH %0t axis %0d slot %h", $time, a, rslot[a]);
        end
        samples_checked++;
        if (resp[a] !== {1'b1, wr, 1'b0})
        begin
          n_errors++;
          $display("MISMATCH %0t axis %0d flags %b", $time, a, resp[a]);
        end
      end
    end
  end
  initial
  begin
    #400000;
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h98d6));
    repeat (8) @(negedge sys_clk_i);
    rstn_i = 1;
    notes.push_back(64'h0);
    rd <= 1'b1;
    repeat (10) @(negedge sys_clk_i);
    for (int i = 1; i < 4; i++)
    begin
      pos <= 32'((4 - i) * 700 + $urandom % 100);
      wr <= 1'b1;
      repeat (6) @(negedge sys_clk_i);
      notes.push_back({pos, pos});
      st <= 1'b1;
      repeat (3) @(negedge sys_clk_i);
      st <= 1'b0;
      repeat (8) @(negedge sys_clk_i);
      if (i == 1)
      begin
        snap = rslot;
        ce <= 1'b0;
        repeat (20) @(negedge sys_clk_i);
        samples_checked++;
        if (rslot !== snap || resp[0].busy !== 1'b1)
        begin
          n_errors++;
          $display("MISMATCH %0t state moved with clock enable low", $time);
        end
        ce <= 1'b1;
      end
      for (int k = 0; k < 3000 && resp[0].busy !== 1'b0; k++)
        @(negedge sys_clk_i);
      if (resp[0].busy !== 1'b0)
      begin
        n_errors++;
        $display("MISMATCH %0t move did not end", $time);
      end
      repeat (4) @(negedge sys_clk_i);
    end
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (8) @(negedge sys_clk_i);
    for (int a = 0; a < 2; a++)
    begin
      samples_checked++;
      if (resp[a].read_active_flag !== 1'b0 || resp[a].write_active_flag !== 1'b0)
      begin
        n_errors++;
        $display("MISMATCH %0t axis %0d flags not cleared", $time, a);
      end
    end
    if (notes.size() != 0)
    begin
      n_errors++;
      $display("MISMATCH %0t %0d results never seen", $time, notes.size());
    end
    wrap_up();
  end
endmodule
